// [cmp_defines.svh]
// register offsets, field positions and encodings of the comparator event block
// assumes byte addressing on a 32-bit wishbone data bus
`ifndef CMP_DEFINES_SVH
`define CMP_DEFINES_SVH

// register windows: address bits 7:4 pick the window, bits 3:2 the access kind
`define CEC_WIN_STAT    4'h8
`define CEC_WIN_FLAG    4'h9
`define CEC_WIN_EN      4'hA
`define CEC_WIN_PRIO    4'hB

// access kinds inside a window
`define CEC_OP_WRITE    2'h0
`define CEC_OP_CLR      2'h1
`define CEC_OP_SET      2'h2
`define CEC_OP_INV      2'h3

// control register fields
`define CEC_ON_BIT      15
`define CEC_INV_BIT     13
`define CEC_RES_BIT     8
`define CEC_EVT_LO      6
`define CEC_CTRL_WMASK  32'h0000A0C0
`define CEC_CTRL_RESET  32'h00000000

// status register fields
`define CEC_FRZ_BIT     14
`define CEC_STOP_IN_IDLE_BIT    13

// flag and enable registers share the same bit positions
`define CEC_FLAG_BASE   3

// priority register: one byte lane per comparator, priority 2:0, subpriority 4:3
`define CEC_PRIO_STRIDE 8
`define CEC_PRIO_WMASK  32'h1F1F1F1F

// event selection codes in the control register
`define CEC_EVT_NONE    2'h0
`define CEC_EVT_RISE    2'h1
`define CEC_EVT_FALL    2'h2
`define CEC_EVT_ANY     2'h3

`endif

// [cmp_pkg.sv]
// shared types of the comparator event block
// assumes cmp_defines.svh carries the numeric constants
`default_nettype none
package cmp_pkg;
    // arbitration rank: priority above subpriority
    typedef logic [4:0] rank_t;
    typedef logic [1:0] evt_mode_t;
endpackage : cmp_pkg

`default_nettype wire

// [cmp_sync.sv]
// three-stage synchroniser with agreement filter for one comparator output
// assumes the input is asynchronous to clk
`timescale 1ns/10ps
`default_nettype none

module cmp_sync (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic async_in,
    output var  logic level_out
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // first stage feeds only the second, never any logic
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            level_out <= 1'b0;
        end else if (s2_reg == s3_reg) begin
            level_out <= s3_reg;
        end
    end
endmodule : cmp_sync

`default_nettype wire

// [cmp_edge.sv]
// result register and change-event detector for one comparator
// assumes a synchronised level; hold freezes the result and blocks event pulses
`timescale 1ns/10ps
`default_nettype none
`include "cmp_defines.svh"

module cmp_edge
    import cmp_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              active,
    input  wire logic              hold,
    input  wire logic              invert,
    input  wire logic              level,
    input  wire cmp_pkg::evt_mode_t mode,
    output var  logic              result,
    output var  logic              event_pulse
);
    logic res_next;
    logic match;

    // polarity applied here; an off comparator reads low
    always_comb begin
        res_next = active ? (level ^ invert) : 1'b0;
        case (mode)
            `CEC_EVT_RISE: match = res_next;
            `CEC_EVT_FALL: match = ~res_next;
            `CEC_EVT_ANY:  match = 1'b1;
            default:       match = 1'b0;
        endcase
    end

    // result tracks the live level so reads see the present value
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            result <= 1'b0;
        end else if (!hold) begin
            result <= res_next;
        end
    end

    // one-cycle pulse on each qualifying change of the result
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            event_pulse <= 1'b0;
        end else begin
            event_pulse <= !hold && active && (res_next != result) && match;
        end
    end
endmodule : cmp_edge

`default_nettype wire

// [comparator_event_control.sv]
// control, status, event flags and interrupt arbitration for the comparators
// assumes a classic wishbone master on clk and raw comparator outputs on cmp_raw;
// idle, sleep, debug and the interrupt acknowledge come from logic on clk
//
// Notes on behaviour
// - a change of a comparator result raises an event when events are selected
// - reading the result bit returns the present synchronised level after the bit 13 polarity
// - control bit 13 inverts the comparator output
// - flags at bits 3 and 4 of flag register, enables at same bits
// - a flag is set on every event whatever its enable
// - interrupt requested only for enabled sources, after arbitration
// - three-bit priority per channel; 7 highest, 0 never interrupts
// - a higher priority group preempts the interrupt in service
// - two-bit subpriority ranks within a group and preempts lower ones
// - equal priority and subpriority: lowest vector number wins
// - losers stay pending and are issued once the current flag clears
// - vector number given to the cpu equals the natural order number
// - idle keeps comparators running unless stop-in-idle bit 13 is set
// - sleep keeps comparators running; an enabled interrupt wakes the device
// - waking from sleep leaves every control register field unchanged
// - clearing control bit 15 turns the comparator off
// - freeze bit 14 at zero lets the block run during debug halt
// - freeze bit set and debug halt: all state held, resumes afterwards; the synchronisers keep running here
// - freeze bit accessible only in debug mode, reads zero otherwise
// - freeze change takes effect at next debug entry; reads show entry value
// - every reset clears control registers, comparators off
// - result bit sits at control bit 8 and is read-only
// - set window at offset 0x8 sets bits written as one
// - invert window at offset 0xC toggles bits written as one
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "cmp_defines.svh"

module comparator_event_control
    import cmp_pkg::*;
#(
    parameter int          NCMP     = 2,
    parameter int          VEC_W    = 6,
    parameter logic [5:0]  VEC_BASE = 6'h01
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic [7:0]        adr_i,
    input  wire logic [31:0]       dat_i,
    output var  logic [31:0]       dat_o,
    input  wire logic              we_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    output var  logic              ack_o,
    input  wire logic [NCMP-1:0]   cmp_raw,
    output var  logic [NCMP-1:0]   cmp_enable,
    input  wire logic              cpu_idle,
    input  wire logic              cpu_sleep,
    input  wire logic              debug_halt,
    input  wire logic              irq_taken,
    output var  logic              irq_req,
    output var  logic [VEC_W-1:0]  irq_vector,
    output var  logic [2:0]        irq_level,
    output var  logic              wake_req
);
    import cmp_pkg::*;

    // one comparator still needs a one-bit index
    localparam int IDX_W = (NCMP > 1) ? $clog2(NCMP) : 1;

    // software-visible state
    logic [31:0]      ctrl_reg [NCMP];
    logic             stop_in_idle_reg;
    logic             frz_wr_reg;
    logic             frz_eff_reg;
    logic [NCMP-1:0]  cmp_event_flag;
    logic [NCMP-1:0]  cmp_event_enable;
    logic [31:0]      prio_reg;
    logic [NCMP-1:0]  svc_reg;
    logic [IDX_W-1:0] idx_reg;

    // decode and arbitration nets
    logic [NCMP-1:0]  sync_level;
    logic [NCMP-1:0]  compare_result;
    logic [NCMP-1:0]  evt;
    logic [NCMP-1:0]  active;
    logic             frozen;
    logic             req;
    logic             wr;
    logic [3:0]       win;
    logic [1:0]       op;
    logic [31:0]      be;
    rank_t            rank [NCMP];
    logic [NCMP-1:0]  cand;
    logic             best_valid;
    rank_t            best_rank;
    logic [IDX_W-1:0] best_idx;
    rank_t            cur_rank;
    logic [31:0]      flag_word;
    logic [31:0]      en_word;
    logic [31:0]      rd_word;
    logic [31:0]      stat_old;
    logic [31:0]      stat_new;

    // one function serves plain, clear, set and invert windows alike
    // unselected byte lanes keep their old value
    function automatic logic [31:0] apply_write(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [31:0] lanes,
        input logic [1:0]  kind
    );
        logic [31:0] m;
        m = wd & lanes;
        case (kind)
            `CEC_OP_CLR: apply_write = old & ~m;
            `CEC_OP_SET: apply_write = old | m;
            `CEC_OP_INV: apply_write = old ^ m;
            default:     apply_write = (old & ~lanes) | m;
        endcase
    endfunction : apply_write

    // bus decode: one access per request, answered one cycle later
    // ack masks the held strobe, so no access is taken twice
    assign req = cyc_i && stb_i && !ack_o;
    assign wr  = req && we_i;
    assign win = adr_i[7:4];
    assign op  = adr_i[3:2];
    assign be  = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

    // freeze only bites while halted in debug with the value caught at entry
    // outside debug a set freeze bit has no effect
    assign frozen = debug_halt && frz_eff_reg;

    // flag and enable bits shown at their register positions
    assign flag_word = 32'(cmp_event_flag) << `CEC_FLAG_BASE;
    assign en_word   = 32'(cmp_event_enable) << `CEC_FLAG_BASE;

    // status as software writes it, for clear, set and invert alike
    assign stat_old = (32'(stop_in_idle_reg) << `CEC_STOP_IN_IDLE_BIT) | (32'(frz_wr_reg) << `CEC_FRZ_BIT);
    assign stat_new = apply_write(stat_old, dat_i, be, op);

    // per-channel front end: synchroniser, polarity and change detector
    genvar g;
    generate
        for (g = 0; g < NCMP; g++) begin : gen_ch
            // stop-in-idle gates every comparator; sleep does not
            assign active[g] = ctrl_reg[g][`CEC_ON_BIT] && !(cpu_idle && stop_in_idle_reg);

            cmp_sync u_sync (
                .clk       (clk),
                .reset     (reset),
                .async_in  (cmp_raw[g]),
                .level_out (sync_level[g])
            );

            // freeze holds result and events, not the synchroniser
            cmp_edge u_edge (
                .clk         (clk),
                .reset       (reset),
                .active      (active[g]),
                .hold        (frozen),
                .invert      (ctrl_reg[g][`CEC_INV_BIT]),
                .level       (sync_level[g]),
                .mode        (ctrl_reg[g][`CEC_EVT_LO +: 2]),
                .result      (compare_result[g]),
                .event_pulse (evt[g])
            );

            // rank is priority over subpriority
            assign rank[g] = {prio_reg[g*`CEC_PRIO_STRIDE +: 3],
                              prio_reg[g*`CEC_PRIO_STRIDE + 3 +: 2]};
            assign cand[g] = cmp_event_flag[g] && cmp_event_enable[g]
                             && (rank[g][4:2] != 3'h0);
        end
    endgenerate

    // control registers; no sleep or wake path touches them
    // write mask drops bit 8, so the result stays read-only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < NCMP; i++) begin
                ctrl_reg[i] <= `CEC_CTRL_RESET;
            end
        end else if (wr) begin
            for (int i = 0; i < NCMP; i++) begin
                if (win == 4'(i)) begin
                    ctrl_reg[i] <= apply_write(ctrl_reg[i], dat_i, be, op)
                                   & `CEC_CTRL_WMASK;
                end
            end
        end
    end

    // status: stop-in-idle always writable, freeze only in debug
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stop_in_idle_reg   <= 1'b0;
            frz_wr_reg <= 1'b0;
        end else if (wr && win == `CEC_WIN_STAT) begin
            stop_in_idle_reg <= stat_new[`CEC_STOP_IN_IDLE_BIT];
            if (debug_halt) begin
                frz_wr_reg <= stat_new[`CEC_FRZ_BIT];
            end
        end
    end

    // effective freeze follows the written bit outside debug, held inside
    // so a write made in debug acts from the next entry on
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            frz_eff_reg <= 1'b0;
        end else if (!debug_halt) begin
            frz_eff_reg <= frz_wr_reg;
        end
    end

    // flags: a hardware event wins over a clear in the same cycle
    // else an event in the clear cycle would be lost
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmp_event_flag <= '0;
        end else if (wr && win == `CEC_WIN_FLAG) begin
            cmp_event_flag <= NCMP'(apply_write(flag_word, dat_i, be, op)
                                    >> `CEC_FLAG_BASE) | evt;
        end else begin
            cmp_event_flag <= cmp_event_flag | evt;
        end
    end

    // enables and priorities are plain software state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmp_event_enable <= '0;
            prio_reg         <= 32'h0;
        end else if (wr) begin
            if (win == `CEC_WIN_EN) begin
                cmp_event_enable <= NCMP'(apply_write(en_word, dat_i, be, op)
                                          >> `CEC_FLAG_BASE);
            end
            if (win == `CEC_WIN_PRIO) begin
                prio_reg <= apply_write(prio_reg, dat_i, be, op) & `CEC_PRIO_WMASK;
            end
        end
    end

    // arbitration: scan from the top so that ties fall to the lowest index
    // cur_rank: highest rank in service, zero if none
    always_comb begin
        best_valid = 1'b0;
        best_rank  = '0;
        best_idx   = '0;
        cur_rank   = '0;
        for (int i = NCMP - 1; i >= 0; i--) begin
            if (cand[i] && (!best_valid || rank[i] >= best_rank)) begin
                best_valid = 1'b1;
                best_rank  = rank[i];
                best_idx   = IDX_W'(i);
            end
            if (svc_reg[i] && rank[i] > cur_rank) begin
                cur_rank = rank[i];
            end
        end
    end

    // in-service set: entered on acknowledge, left when software clears the flag
    // held while frozen so nesting resumes intact
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            svc_reg <= '0;
        end else if (!frozen) begin
            for (int i = 0; i < NCMP; i++) begin
                if (!cmp_event_flag[i]) begin
                    svc_reg[i] <= 1'b0;
                end else if (irq_taken && irq_req && idx_reg == IDX_W'(i)) begin
                    svc_reg[i] <= 1'b1;
                end
            end
        end
    end

    // request only when strictly above everything in service, so equals wait
    // limitation: an equal source waits for the flag clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_req    <= 1'b0;
            idx_reg    <= '0;
            irq_vector <= '0;
            irq_level  <= 3'h0;
        end else if (!frozen) begin
            irq_req    <= best_valid && (best_rank > cur_rank) && !irq_taken;
            idx_reg    <= best_idx;
            irq_vector <= VEC_W'(VEC_BASE) + VEC_W'(best_idx);
            irq_level  <= best_rank[4:2];
        end
    end

    // wake and analog enables are registered straight to the pins
    // wake ignores priority: any enabled flag will do
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wake_req   <= 1'b0;
            cmp_enable <= '0;
        end else begin
            wake_req   <= cpu_sleep && |(cmp_event_flag & cmp_event_enable);
            cmp_enable <= active;
        end
    end

    // read mux; the clear, set and invert windows just mirror the register
    // status results are the same registered bits as control bit 8
    always_comb begin
        rd_word = 32'h0;
        for (int i = 0; i < NCMP; i++) begin
            if (win == 4'(i)) begin
                rd_word = ctrl_reg[i]
                          | (32'(compare_result[i]) << `CEC_RES_BIT);
            end
        end
        case (win)
            `CEC_WIN_STAT: rd_word = 32'(compare_result)
                                     | (32'(stop_in_idle_reg) << `CEC_STOP_IN_IDLE_BIT)
                                     | (32'(debug_halt && frz_eff_reg) << `CEC_FRZ_BIT);
            `CEC_WIN_FLAG: rd_word = flag_word;
            `CEC_WIN_EN:   rd_word = en_word;
            `CEC_WIN_PRIO: rd_word = prio_reg;
            default:       rd_word = rd_word;
        endcase
    end

    // single-cycle acknowledge; unmapped addresses answer zero and drop writes
    // one wait state buys a registered read path
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= req;
            if (req && !we_i) begin
                dat_o <= rd_word;
            end
        end
    end
endmodule : comparator_event_control

`default_nettype wire

// [cmp_event_properties.sv]
// port-level checks on the comparator event block
// assumes one clock domain with an active-high async reset
`timescale 1ns/10ps
`default_nettype none

module cmp_event_checker #(
    parameter int         NCMP     = 2,
    parameter int         VEC_W    = 6,
    parameter logic [5:0] VEC_BASE = 6'h01
) (
    input wire logic             clk,
    input wire logic             reset,
    input wire logic             cyc_i,
    input wire logic             stb_i,
    input wire logic             ack_o,
    input wire logic [NCMP-1:0]  cmp_enable,
    input wire logic             cpu_idle,
    input wire logic             cpu_sleep,
    input wire logic             irq_taken,
    input wire logic             irq_req,
    input wire logic [VEC_W-1:0] irq_vector,
    input wire logic [2:0]       irq_level,
    input wire logic             wake_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // one ack pulse, one cycle after a request is taken
    ack_resp_a: assert property (
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o) else $error("bus ack late or long");
    ack_idle_a: assert property (
        !(cyc_i && stb_i) |=> !ack_o) else $error("ack without request");
    vector_range_a: assert property (
        irq_req |-> irq_vector >= VEC_BASE && irq_vector < VEC_BASE + NCMP)
        else $error("vector outside source range");
    level_nonzero_a: assert property (
        irq_req |-> irq_level != 3'h0) else $error("request at priority zero");
    taken_drop_a: assert property (
        irq_taken && irq_req |=> !irq_req) else $error("request stays after take");
    wake_cause_a: assert property (
        wake_req |-> $past(cpu_sleep)) else $error("wake without sleep");
    reset_off_a: assert property (
        $fell(reset) |-> cmp_enable == '0 && !irq_req) else $error("not off after reset");
    // enables move only after a bus write or an idle change
    enable_stable_a: assert property (
        !(cyc_i && stb_i) && !$past(cyc_i && stb_i) && !$past(cyc_i && stb_i, 2)
        && $stable(cpu_idle) && $past(cpu_idle, 2) == cpu_idle |-> $stable(cmp_enable))
        else $error("enable changed without cause");
endmodule : cmp_event_checker

bind comparator_event_control cmp_event_checker #(
    .NCMP(NCMP), .VEC_W(VEC_W), .VEC_BASE(VEC_BASE)
) chk_i (.clk, .reset, .cyc_i, .stb_i, .ack_o, .cmp_enable, .cpu_idle, .cpu_sleep,
    .irq_taken, .irq_req, .irq_vector, .irq_level, .wake_req);

`default_nettype wire

// [cmp_partner.sv]
// analog comparator core and cpu interrupt acknowledge, behavioural
// assumes the bench sets target levels and enables the acknowledge
`timescale 1ns/10ps
`default_nettype none

module cmp_partner #(
    parameter int VEC_W = 6
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [1:0]       level,
    input  wire logic             auto_ack,
    input  wire logic             irq_req,
    input  wire logic [VEC_W-1:0] irq_vector,
    output var  logic [1:0]       cmp_raw,
    output var  logic             irq_taken,
    output var  logic [VEC_W-1:0] taken_vec
);
    // core output lags its inputs, off the clock grid on purpose
    initial cmp_raw = 2'h0;
    always @(level) cmp_raw <= #1.3 level;

    // cpu takes each request one cycle after seeing it, one pulse only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_taken <= 1'h0;
            taken_vec <= '0;
        end else begin
            irq_taken <= auto_ack && irq_req && !irq_taken;
            if (irq_taken && irq_req) taken_vec <= irq_vector;
        end
    end
endmodule : cmp_partner

`default_nettype wire

// [comparator_event_control_tb.sv]
// self-checking bench for the comparator event block
// assumes default parameters and the register map of cmp_defines.svh
`timescale 1ns/10ps
`default_nettype none
`include "cmp_defines.svh"

module comparator_event_control_tb;
    localparam logic [5:0] VB = 6'h01;
    logic        clk = 1'h0;
    logic        reset, we_i, cyc_i, stb_i, ack_o, cpu_idle, cpu_sleep, debug_halt;
    logic        irq_taken, irq_req, wake_req, auto_ack, pr;
    logic [7:0]  adr_i;
    logic [31:0] dat_i, dat_o, rd, d;
    logic [3:0]  sel_i;
    logic [1:0]  cmp_raw, cmp_enable, lvl;
    logic [5:0]  irq_vector, taken_vec;
    logic [2:0]  irq_level;
    int          err_count, n_compared, seed, k;

    always #2 clk = ~clk;

    comparator_event_control uut (.clk(clk), .reset(reset), .adr_i(adr_i), .dat_i(dat_i),
        .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .ack_o(ack_o), .cmp_raw(cmp_raw), .cmp_enable(cmp_enable), .cpu_idle(cpu_idle),
        .cpu_sleep(cpu_sleep), .debug_halt(debug_halt), .irq_taken(irq_taken),
        .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level),
        .wake_req(wake_req));
    cmp_partner far (.clk(clk), .reset(reset), .level(lvl), .auto_ack(auto_ack),
        .irq_req(irq_req), .irq_vector(irq_vector), .cmp_raw(cmp_raw),
        .irq_taken(irq_taken), .taken_vec(taken_vec));

    task complete_run;
        $display("compared %0d, errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run

    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            $display("Error at %0t: got %h expected %h", $time, g, e);
            err_count++;
        end
    endtask : chk

    // classic cycle: hold until ack is sampled, then release
    task wb(input logic w, input logic [7:0] a, input logic [31:0] dd);
        int i;
        @(posedge clk);
        {cyc_i, stb_i, we_i} <= {2'h3, w};
        adr_i <= a;
        dat_i <= dd;
        for (i = 0; i < 50 && ack_o !== 1'h1; i++) @(posedge clk);
        if (i == 50) begin
            err_count++;
            complete_run();
        end
        rd = dat_o;
        {cyc_i, stb_i} <= 2'h0;
    endtask : wb

    // result and flag need six edges; ten leaves margin
    task flip(input logic [1:0] m);
        @(posedge clk);
        lvl <= lvl ^ m;
        repeat (10) @(posedge clk);
    endtask : flip

    function automatic logic [31:0] ctrl_exp(input logic [31:0] dd, input logic r);
        return (dd & `CEC_CTRL_WMASK) | (32'(r) << `CEC_RES_BIT);
    endfunction : ctrl_exp

    // channel one flags a change only where its event select wants the new level
    function automatic logic [31:0] evt_exp(input logic o, input logic n, input logic [1:0] m);
        logic hit;
        hit = (o != n) && (m == `CEC_EVT_ANY || (m == `CEC_EVT_RISE && n)
                           || (m == `CEC_EVT_FALL && !n));
        return {27'h0, hit, 4'h0};
    endfunction : evt_exp

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        complete_run();
    end

    initial begin
        {reset, we_i, cyc_i, stb_i, cpu_idle, cpu_sleep, debug_halt, auto_ack} = 8'h80;
        {adr_i, dat_i, lvl, sel_i} = {8'h00, 32'h0, 2'h0, 4'hF};
        {err_count, n_compared, seed} = {32'h0, 32'h0, 32'h709B};
        pr = 1'h0;
        repeat (6) @(posedge clk);
        reset <= 1'h0;
        wb(0, 8'h00, 32'h0); chk(rd, 32'h0);
        chk(32'(cmp_enable), 32'h0);
        wb(0, 8'h70, 32'h0); chk(rd, 32'h0);
        // random control words; result bit must not take written data
        for (k = 0; k < 8; k++) begin
            d = $random(seed) | 32'h8000;
            wb(1, 8'h94, 32'h10);
            wb(1, 8'h10, d);
            flip(2'h0);
            wb(0, 8'h10, 32'h0); chk(rd, ctrl_exp(d, d[13]));
            wb(0, 8'h90, 32'h0); chk(rd & 32'h10, evt_exp(pr, d[13], d[7:6]));
            pr = d[13];
        end
        wb(1, 8'h94, 32'h18);
        wb(1, 8'h00, 32'h80C0);
        flip(2'h1); chk(32'(cmp_enable[0]), 32'h1);
        wb(0, 8'h80, 32'h0); chk(rd & 32'h3, {30'h0, d[13], 1'h1});
        wb(0, 8'h90, 32'h0); chk(rd & 32'h18, 32'h08);
        chk(32'(irq_req), 32'h0);
        wb(1, 8'h08, 32'h2000); flip(2'h0);
        wb(0, 8'h00, 32'h0); chk(rd, ctrl_exp(32'hA0C0, 1'h0));
        wb(1, 8'h0C, 32'h2000); flip(2'h0);
        wb(0, 8'h00, 32'h0); chk(rd, ctrl_exp(32'h80C0, 1'h1));
        // priority zero stays silent, then equal ranks by natural order
        wb(1, 8'h10, 32'h80C0); wb(1, 8'hB0, 32'h0);
        wb(1, 8'h94, 32'h18); wb(1, 8'hA0, 32'h18);
        flip(2'h3); chk(32'(irq_req), 32'h0);
        wb(1, 8'hB0, 32'h0505); flip(2'h0);
        chk(32'(irq_vector), 32'(VB));
        chk(32'(irq_level), 32'h5);
        auto_ack <= 1'h1; flip(2'h0); chk(32'(taken_vec), 32'(VB));
        wb(1, 8'h94, 32'h08); flip(2'h0); chk(32'(taken_vec), 32'(VB + 6'h01));
        wb(1, 8'h94, 32'h10); flip(2'h0);
        // preemption by group, then by subpriority in one group
        for (k = 0; k < 2; k++) begin
            wb(1, 8'hB0, (k == 0) ? 32'h0503 : 32'h1C04);
            flip(2'h1); chk(32'(taken_vec), 32'(VB));
            flip(2'h2); chk(32'(taken_vec), 32'(VB + 6'h01));
            wb(1, 8'h94, 32'h18); flip(2'h0);
        end
        auto_ack <= 1'h0; cpu_sleep <= 1'h1;
        flip(2'h1); chk(32'(wake_req), 32'h1);
        cpu_sleep <= 1'h0;
        wb(0, 8'h00, 32'h0); chk(rd, ctrl_exp(32'h80C0, lvl[0]));
        wb(1, 8'h94, 32'h18);
        wb(1, 8'h88, 32'h2000); cpu_idle <= 1'h1;
        flip(2'h0); chk(32'(cmp_enable), 32'h0);
        wb(1, 8'h84, 32'h2000); flip(2'h0); chk(32'(cmp_enable), 32'h3);
        cpu_idle <= 1'h0;
        // turning back on raised both flags; clear them first
        wb(1, 8'h94, 32'h18);
        // freeze written in debug acts only from the next debug entry
        wb(1, 8'h88, 32'h4000); debug_halt <= 1'h1;
        wb(1, 8'h88, 32'h4000); wb(0, 8'h80, 32'h0); chk(rd & 32'h4000, 32'h0);
        flip(2'h1); wb(0, 8'h90, 32'h0); chk(rd & 32'h18, 32'h08);
        debug_halt <= 1'h0;
        wb(0, 8'h80, 32'h0); chk(rd & 32'h4000, 32'h0);
        wb(1, 8'h94, 32'h18); debug_halt <= 1'h1;
        wb(0, 8'h80, 32'h0); chk(rd & 32'h4000, 32'h4000);
        flip(2'h1); wb(0, 8'h90, 32'h0); chk(rd & 32'h18, 32'h0);
        debug_halt <= 1'h0;
        flip(2'h0); wb(0, 8'h90, 32'h0); chk(rd & 32'h18, 32'h08);
        wb(1, 8'h04, 32'h8000); flip(2'h0); chk(32'(cmp_enable[0]), 32'h0);
        // reset in mid-run
        @(posedge clk); reset <= 1'h1;
        @(posedge clk); reset <= 1'h0;
        wb(0, 8'h10, 32'h0); chk(rd, 32'h0);
        chk(32'(cmp_enable), 32'h0);
        complete_run();
    end
endmodule : comparator_event_control_tb

`default_nettype wire
